// ---- rtl/sarfmt_top.sv ----
`timescale 1ns/1ps
module sarfmt_top (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Special-function register bus
   input wire sarfmt_pkg::sarfmt_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   // Conversion control from the converter core
   input wire logic conv_start,
   input wire logic delayed_tracking_mode,
   input wire logic done_clear,
   // Analog front end
   input wire logic comp_above,
   output logic [9:0] dac_trial,
   output logic track_enable,
   output logic gain_select,
   output logic eight_bit_mode_enable,
   // Status
   output logic busy_indication,
   output logic conversion_done_flag
);

   sarfmt_pkg::sarfmt_regs_t r;
   sarfmt_pkg::sarfmt_regs_t n;
   logic sar_tick;
   logic busy_run;

   function automatic logic [1:0] sarfmt_decode(input logic [7:0] addr);
      logic [1:0] sel;
      sel = sarfmt_pkg::SARFMT_SEL_NONE;
      if (addr == sarfmt_pkg::SARFMT_CFG_ADDR) begin
         sel = sarfmt_pkg::SARFMT_SEL_CFG;
      end else if (addr == sarfmt_pkg::SARFMT_LOW_ADDR) begin
         sel = sarfmt_pkg::SARFMT_SEL_LOW;
      end else if (addr == sarfmt_pkg::SARFMT_HIGH_ADDR) begin
         sel = sarfmt_pkg::SARFMT_SEL_HIGH;
      end
      return sel;
   endfunction

   // Returns {high byte, low byte}; unused bits are always zero
   function automatic logic [15:0] sarfmt_format(input logic [9:0] code,
                                                 input logic eight,
                                                 input logic just);
      logic [15:0] pair;
      pair = 16'h0000;
      if (eight) begin
         pair = {code[9:2], 8'h00};
      end else if (just) begin
         pair = {code[9:2], code[1:0], 6'h00};
      end else begin
         pair = {6'h00, code[9:8], code[7:0]};
      end
      return pair;
   endfunction

   assign busy_run = (r.st != sarfmt_pkg::SARFMT_IDLE);

   sarfmt_clkdiv #(
      .DIV_W(sarfmt_pkg::SARFMT_DIV_W)
   ) u_clkdiv (
      .clock(clock),
      .rst(rst),
      .run(busy_run),
      .divisor(r.cfg[sarfmt_pkg::SARFMT_DIV_MSB:sarfmt_pkg::SARFMT_DIV_LSB]),
      .tick(sar_tick)
   );

   always_comb begin
      logic [9:0] settled;
      logic [9:0] last_mask;
      logic [15:0] pair;
      logic finish;
      settled = 10'h000;
      last_mask = 10'h000;
      pair = 16'h0000;
      finish = 1'b0;
      n = r;

      // Read data is registered: it answers one cycle after the address
      unique case (sarfmt_decode(sfr_req.addr))
         sarfmt_pkg::SARFMT_SEL_CFG: n.rdata = r.cfg;
         sarfmt_pkg::SARFMT_SEL_LOW: n.rdata = r.res_lo;
         sarfmt_pkg::SARFMT_SEL_HIGH: n.rdata = r.res_hi;
         default: n.rdata = 8'h00;
      endcase

      if (sfr_req.wr) begin
         unique case (sarfmt_decode(sfr_req.addr))
            sarfmt_pkg::SARFMT_SEL_CFG: n.cfg = sfr_req.wdata;
            sarfmt_pkg::SARFMT_SEL_LOW: n.res_lo = sfr_req.wdata;
            sarfmt_pkg::SARFMT_SEL_HIGH: n.res_hi = sfr_req.wdata;
            default: n.cfg = r.cfg;
         endcase
      end

      unique case (r.st)
         sarfmt_pkg::SARFMT_IDLE: begin
            // Mode and layout are frozen for the whole conversion
            if (conv_start) begin
               n.eight = r.cfg[sarfmt_pkg::SARFMT_EIGHT_BIT];
               n.just = r.cfg[sarfmt_pkg::SARFMT_JUST_BIT];
               n.trk = 2'h0;
               n.trial = sarfmt_pkg::SARFMT_MSB_MASK;
               n.mask = sarfmt_pkg::SARFMT_MSB_MASK;
               if (delayed_tracking_mode) begin
                  n.st = sarfmt_pkg::SARFMT_TRACK;
               end else begin
                  n.st = sarfmt_pkg::SARFMT_CONV;
               end
            end
         end
         sarfmt_pkg::SARFMT_TRACK: begin
            if (sar_tick) begin
               if (r.trk == sarfmt_pkg::SARFMT_TRACK_LAST) begin
                  n.st = sarfmt_pkg::SARFMT_CONV;
               end else begin
                  n.trk = r.trk + 2'h1;
               end
            end
         end
         sarfmt_pkg::SARFMT_CONV: begin
            if (sar_tick) begin
               settled = comp_above ? r.trial : (r.trial & ~r.mask);
               last_mask = r.eight ? sarfmt_pkg::SARFMT_LSB8_MASK
                                   : sarfmt_pkg::SARFMT_LSB10_MASK;
               if (r.mask == last_mask) begin
                  finish = 1'b1;
                  pair = sarfmt_format(settled, r.eight, r.just);
                  // Hardware load beats a same-cycle software write
                  n.res_hi = pair[15:8];
                  n.res_lo = pair[7:0];
                  n.trial = settled;
                  n.st = sarfmt_pkg::SARFMT_IDLE;
               end else begin
                  n.mask = r.mask >> 1;
                  n.trial = settled | (r.mask >> 1);
               end
            end
         end
         default: n.st = sarfmt_pkg::SARFMT_IDLE;
      endcase

      // A completion in the clearing cycle is kept
      n.done = finish | (r.done & ~done_clear);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         r.st <= sarfmt_pkg::SARFMT_IDLE;
         r.cfg <= sarfmt_pkg::SARFMT_CFG_RESET;
         r.res_hi <= sarfmt_pkg::SARFMT_RESULT_RESET;
         r.res_lo <= sarfmt_pkg::SARFMT_RESULT_RESET;
         r.trial <= 10'h000;
         r.mask <= 10'h000;
         r.trk <= 2'h0;
         r.eight <= 1'b0;
         r.just <= 1'b0;
         r.done <= 1'b0;
         r.rdata <= 8'h00;
      end else begin
         r <= n;
      end
   end

   assign sfr_rdata = r.rdata;
   assign dac_trial = r.trial;
   assign track_enable = (r.st != sarfmt_pkg::SARFMT_CONV);
   assign gain_select = r.cfg[sarfmt_pkg::SARFMT_GAIN_BIT];
   assign eight_bit_mode_enable = r.cfg[sarfmt_pkg::SARFMT_EIGHT_BIT];
   assign busy_indication = busy_run;
   assign conversion_done_flag = r.done;

endmodule

// ---- common/sarfmt_pkg.sv ----
package sarfmt_pkg;

   // Register addresses on the special-function register bus
   localparam logic [7:0] SARFMT_CFG_ADDR = 8'hBC;
   localparam logic [7:0] SARFMT_LOW_ADDR = 8'hBD;
   localparam logic [7:0] SARFMT_HIGH_ADDR = 8'hBE;

   // Values after reset
   localparam logic [7:0] SARFMT_CFG_RESET = 8'hF9;
   localparam logic [7:0] SARFMT_RESULT_RESET = 8'h00;

   // Field positions inside converter_config
   localparam int SARFMT_DIV_MSB = 7;
   localparam int SARFMT_DIV_LSB = 3;
   localparam int SARFMT_JUST_BIT = 2;
   localparam int SARFMT_EIGHT_BIT = 1;
   localparam int SARFMT_GAIN_BIT = 0;

   // Conversion geometry and timing, in SAR clock cycles
   localparam int SARFMT_CODE_W = 10;
   localparam int SARFMT_DIV_W = 5;
   localparam logic [1:0] SARFMT_TRACK_LAST = 2'h2;
   localparam logic [9:0] SARFMT_MSB_MASK = 10'h200;
   localparam logic [9:0] SARFMT_LSB10_MASK = 10'h001;
   localparam logic [9:0] SARFMT_LSB8_MASK = 10'h004;

   // Register select codes returned by the address decoder
   localparam logic [1:0] SARFMT_SEL_NONE = 2'h0;
   localparam logic [1:0] SARFMT_SEL_CFG = 2'h1;
   localparam logic [1:0] SARFMT_SEL_LOW = 2'h2;
   localparam logic [1:0] SARFMT_SEL_HIGH = 2'h3;

   typedef enum logic [2:0] {
      SARFMT_IDLE = 3'h1,
      SARFMT_TRACK = 3'h2,
      SARFMT_CONV = 3'h4
   } sarfmt_state_t;

   // One bus access: address, write strobe and write data
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic [7:0] wdata;
   } sarfmt_sfr_req_t;

   typedef struct packed {
      sarfmt_state_t st;
      logic [7:0] cfg;
      logic [7:0] res_hi;
      logic [7:0] res_lo;
      logic [9:0] trial;
      logic [9:0] mask;
      logic [1:0] trk;
      logic eight;
      logic just;
      logic done;
      logic [7:0] rdata;
   } sarfmt_regs_t;

   typedef struct packed {
      logic [4:0] cnt;
      logic tick;
   } sarfmt_div_regs_t;

endpackage

// ---- rtl/sarfmt_clkdiv.sv ----
`timescale 1ns/1ps
module sarfmt_clkdiv #(
   parameter int DIV_W = 5
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Control
   input wire logic run,
   input wire logic [DIV_W-1:0] divisor,
   // SAR clock enable
   output logic tick
);

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
   } sarfmt_div_state_t;

   sarfmt_div_state_t r;
   sarfmt_div_state_t n;

   generate
      if (DIV_W < 1 || DIV_W > 16) begin : g_bad_width
         $error("sarfmt_clkdiv: DIV_W out of range");
      end
   endgenerate

   // Held at zero while idle so every conversion starts on a fresh period.
   // The enable is decoded from the count, not registered: a registered
   // pulse lags one cycle and survives into the next conversion.
   always_comb begin
      n = r;
      tick = 1'b0;
      if (!run) begin
         n.cnt = '0;
      end else if (r.cnt == divisor) begin
         n.cnt = '0;
         tick = 1'b1;
      end else begin
         n.cnt = r.cnt + 1'b1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

endmodule

// ---- bench/sarfmt_comp_model.sv ----
`timescale 1ns/1ps
module sarfmt_comp_model (
   // Input voltage as an ideal code
   input wire logic [9:0] level,
   // Trial code from the DAC
   input wire logic [9:0] dac_trial,
   // Decision
   output logic comp_above
);
   assign comp_above = (level >= dac_trial);
endmodule

// ---- bench/sarfmt_monitor.sv ----
`timescale 1ns/1ps
module sarfmt_monitor (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Register bus
   input wire sarfmt_pkg::sarfmt_sfr_req_t sfr_req,
   input wire logic [7:0] sfr_rdata,
   // Control and status
   input wire logic conv_start,
   input wire logic delayed_tracking_mode,
   input wire logic done_clear,
   input wire logic track_enable,
   input wire logic gain_select,
   input wire logic eight_bit_mode_enable,
   input wire logic busy_indication,
   input wire logic conversion_done_flag
);
   logic [7:0] cfg_q;
   logic [8:0] cnt_q;
   logic [8:0] len_q;
   logic eight_q;
   wire cfg_wr = sfr_req.wr && sfr_req.addr == 8'hBC;
   wire start = conv_start && !busy_indication;
   wire unmapped = sfr_req.addr < 8'hBC || sfr_req.addr > 8'hBE;
   // Shadow config; assumes no config write while converting
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cfg_q <= 8'hF9;
         cnt_q <= '0;
         len_q <= '0;
         eight_q <= 1'b0;
      end else begin
         if (cfg_wr) cfg_q <= sfr_req.wdata;
         cnt_q <= busy_indication ? cnt_q + 9'h001 : 9'h000;
         if (start) begin
            eight_q <= cfg_q[1];
            len_q <= 9'((cfg_q[7:3] + 1) * ((cfg_q[1] ? 8 : 10)
               + (delayed_tracking_mode ? 3 : 0)));
         end
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   AST_GAIN: assert property (cfg_wr |=> gain_select == cfg_q[0])
      else $error("gain select does not follow config");
   AST_MODE: assert property (
      cfg_wr |=> eight_bit_mode_enable == cfg_q[1])
      else $error("eight-bit enable does not follow config");
   AST_BUSY_START: assert property (start |=> busy_indication)
      else $error("busy did not rise after start");
   AST_DONE_SET: assert property (
      $fell(busy_indication) |-> conversion_done_flag)
      else $error("done not set at busy fall");
   AST_DONE_HOLD: assert property (
      conversion_done_flag && !done_clear |=> conversion_done_flag)
      else $error("done flag dropped without clear");
   AST_TRACK_DELAY: assert property (
      start && delayed_tracking_mode |=> track_enable [*3])
      else $error("tracking not held after delayed start");
   AST_CONV_LEN: assert property (
      $fell(busy_indication) |-> cnt_q == len_q)
      else $error("conversion length wrong");
   AST_UNMAPPED: assert property (unmapped |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_LOW8: assert property (
      sfr_req.addr == 8'hBD && eight_q && conversion_done_flag
      |=> sfr_rdata == 8'h00)
      else $error("low byte not zero in eight-bit mode");
   cover property (start && delayed_tracking_mode);
   cover property ($fell(busy_indication) && eight_q);
   cover property (conv_start && busy_indication);
endmodule

// ---- bench/sarfmt_top_test.sv ----
`timescale 1ns/1ps
module sarfmt_top_test;
   localparam logic [7:0] CFGS [4] = '{8'h00, 8'h05, 8'h0B, 8'h0E};
   logic clock = 1'b0;
   logic rst = 1'b1;
   sarfmt_pkg::sarfmt_sfr_req_t sfr_req = '0;
   logic [7:0] sfr_rdata;
   logic conv_start = 1'b0;
   logic delayed_tracking_mode = 1'b0;
   logic done_clear = 1'b0;
   logic comp_above;
   logic [9:0] dac_trial;
   logic [9:0] level = 10'h000;
   logic track_enable, gain_select, eight_bit_mode_enable;
   logic busy_indication, conversion_done_flag;
   int num_errors = 0;
   int n_compared = 0;
   always #12.5 clock = ~clock;
   sarfmt_top u_sarfmt_top (.clock, .rst, .sfr_req, .sfr_rdata, .conv_start,
      .delayed_tracking_mode, .done_clear, .comp_above, .dac_trial,
      .track_enable, .gain_select, .eight_bit_mode_enable,
      .busy_indication, .conversion_done_flag);
   sarfmt_comp_model u_sarfmt_comp_model (.level, .dac_trial, .comp_above);
   task automatic wrap_up();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      sfr_req = '{addr: a, wr: 1'b1, wdata: d};
      @(negedge clock);
      sfr_req.wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clock);
      sfr_req = '{addr: a, wr: 1'b0, wdata: 8'h00};
      @(negedge clock);
      check(16'(sfr_rdata), 16'(exp));
   endtask
   // Expected high:low pair from the mode bits and the input code
   function automatic logic [15:0] fmt(input logic [7:0] c, input logic [9:0] v);
      if (c[1]) return {v[9:2], 8'h00};
      if (c[2]) return {v, 6'h00};
      return {6'h00, v};
   endfunction
   task automatic conv(input logic [7:0] c, input logic dly);
      int n;
      int len;
      logic [15:0] res;
      len = (c[7:3] + 1) * ((c[1] ? 8 : 10) + (dly ? 3 : 0));
      res = fmt(c, level);
      wr(8'hBC, c);
      check(16'(gain_select), 16'(c[0]));
      check(16'(eight_bit_mode_enable), 16'(c[1]));
      delayed_tracking_mode = dly;
      conv_start = 1'b1;
      @(negedge clock);
      conv_start = 1'b0;
      // A second start while busy must not stretch the conversion
      for (n = 1; n < 600 && conversion_done_flag !== 1'b1; n++) begin
         conv_start = (n == 2);
         @(negedge clock);
      end
      if (n >= 600) begin
         num_errors++;
         wrap_up();
      end
      // Each pass looks one cycle after its edge, so n ends one past busy
      check(16'(n - 1), 16'(len));
      rd(8'hBE, res[15:8]);
      rd(8'hBD, res[7:0]);
      done_clear = 1'b1;
      @(negedge clock);
      done_clear = 1'b0;
      check(16'(conversion_done_flag), 16'h0000);
   endtask
   initial begin
      repeat (3) @(negedge clock);
      rst = 1'b0;
      rd(8'hBC, 8'hF9);
      rd(8'hBD, 8'h00);
      rd(8'hBE, 8'h00);
      rd(8'hBF, 8'h00);
      $display("reset values test done");
      wr(8'hBD, 8'h5A);
      rd(8'hBD, 8'h5A);
      wr(8'hBE, 8'hA5);
      rd(8'hBE, 8'hA5);
      $display("result register access test done");
      for (int i = 0; i < 4; i++) begin
         level = 10'h2D7 + 10'(i * 77);
         conv(CFGS[i], i[1]);
         $display("conversion test %0d done", i);
      end
      wrap_up();
   end
endmodule
bind sarfmt_top sarfmt_monitor u_sarfmt_monitor (.clock, .rst, .sfr_req,
   .sfr_rdata, .conv_start, .delayed_tracking_mode, .done_clear,
   .track_enable, .gain_select, .eight_bit_mode_enable,
   .busy_indication, .conversion_done_flag);
